// >>> design/sarc_ctrl.sv
/*
 * Successive-approximation converter control: mode, reference, converter
 * clock divider, start handling, sample/distribution/calibration sequence
 * and result justification, with registers reached over AXI4-Lite.
 * Assumes one system clock; the analog array supplies raw conversion bits.
 */
// Operation
// - Three resolutions chosen by two-bit field
// - 8-bit result on top bits, low four zero
// - 10-bit result on top bits, low two zero
// - Mode bit3 low adds two-tick calibration
// - Mode bit2 low powers down after conversion
// - Reference select: 0 internal, 1 external
// - Converter period is 4*(1+divider) system clocks
// - Converter clock never exposed as output
// - Inputs sampled on clock; start acts each clock it is high
// - Conversion runs two or three sequential phases
// - Busy and sampling rise at sample start
// - Sample lasts 2+sample_time_count converter ticks
// - Distribution: sampling low, one tick per bit
// - Result valid rises with busy fall, holds
`timescale 1ns/1ns
`default_nettype none
`include "sarc_regs.svh"

module sarc_ctrl
   import sarc_pkg::*;
#(
   parameter int AW    = 12,
   parameter int DIV_W = 8,
   parameter int STC_W = 8,
   parameter int RES_W = 12
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [AW-1:0]    s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [AW-1:0]    s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic             conversion_start,
   input  wire logic [RES_W-1:0] sar_raw,
   output logic [RES_W-1:0]      result,
   output logic                  busy,
   output logic                  sampling,
   output logic                  result_valid,
   output logic                  calibrating,
   output logic                  converter_powered,
   output logic                  reference_select
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   sarc_phase_e      phase_r;
   logic [3:0]       mode_r;
   logic             ref_r;
   logic [DIV_W-1:0] div_r;
   logic [STC_W-1:0] stc_r;
   logic [8:0]       cnt_r;
   logic [3:0]       nbits;
   logic             tick;
   logic             start;
   logic             sw_start;
   logic             wr_en;
   logic [AW-1:0]    wr_addr;
   logic [31:0]      wr_data;
   logic [3:0]       wr_strb;
   logic             wr_err;
   logic [AW-1:0]    rd_addr;
   logic [31:0]      rd_data;
   logic             rd_err;
   logic [8:0]       sample_len;
   logic             conv_done;

   // ----------------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------------
   sarc_axil #(
      .AW (AW)
   ) u_axil (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_err        (wr_err),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // Result and status are read-only; writes there answer with an error
   assign wr_err = !(wr_addr == `SARC_CTRL_OFS || wr_addr == `SARC_TIMING_OFS);
   assign rd_err = !(rd_addr == `SARC_CTRL_OFS || rd_addr == `SARC_TIMING_OFS
                  || rd_addr == `SARC_STATUS_OFS
                  || rd_addr == `SARC_RESULT_OFS);

   // Software start: write a one to the start bit of the control register
   assign sw_start = wr_en && wr_addr == `SARC_CTRL_OFS && wr_strb[1]
                     && wr_data[`SARC_CTRL_START_BIT];
   assign start    = conversion_start || sw_start;

   // Read mux
   always_comb begin
      rd_data = '0;
      case (rd_addr)
         `SARC_CTRL_OFS: begin
            rd_data[3:0]                = mode_r;
            rd_data[`SARC_CTRL_REF_BIT] = ref_r;
         end
         `SARC_TIMING_OFS: begin
            rd_data[`SARC_TIM_DIV_HI:`SARC_TIM_DIV_LO] = div_r;
            rd_data[`SARC_TIM_STC_HI:`SARC_TIM_STC_LO] = stc_r;
         end
         `SARC_STATUS_OFS: begin
            rd_data[`SARC_ST_BUSY_BIT]   = busy;
            rd_data[`SARC_ST_SAMPLE_BIT] = sampling;
            rd_data[`SARC_ST_VALID_BIT]  = result_valid;
            rd_data[`SARC_ST_PWR_BIT]    = converter_powered;
         end
         `SARC_RESULT_OFS: begin
            rd_data[RES_W-1:0] = result;
         end
         default: begin
            rd_data = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   // Mode and reference are sampled on the system clock like every input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= `SARC_CTRL_RST;
         ref_r  <= 1'b0;
      end else if (wr_en && wr_addr == `SARC_CTRL_OFS && wr_strb[0]) begin
         mode_r <= wr_data[3:0];
         ref_r  <= wr_data[`SARC_CTRL_REF_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= `SARC_DIV_RST;
         stc_r <= `SARC_STC_RST;
      end else if (wr_en && wr_addr == `SARC_TIMING_OFS) begin
         if (wr_strb[0]) begin
            div_r <= wr_data[`SARC_TIM_DIV_HI:`SARC_TIM_DIV_LO];
         end
         if (wr_strb[1]) begin
            stc_r <= wr_data[`SARC_TIM_STC_HI:`SARC_TIM_STC_LO];
         end
      end
   end

   // Reference choice reaches the analog switch one clock after ref_r
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reference_select <= 1'b0;
      end else begin
         reference_select <= ref_r;
      end
   end

   // ----------------------------------------------------------------------
   // Converter clock
   // ----------------------------------------------------------------------
   // Tick stays internal; realigned on start so the sample count is exact
   sarc_clkdiv #(
      .DIV_W (DIV_W)
   ) u_clkdiv (
      .aclk    (aclk),
      .aresetn (aresetn),
      .restart (start),
      .div     (div_r),
      .tick    (tick)
   );

   // ----------------------------------------------------------------------
   // Resolution and phase lengths
   // ----------------------------------------------------------------------
   // Unused code 11 falls back to 12 bits rather than stalling
   always_comb begin
      case (mode_r[`SARC_CTRL_RES_HI:`SARC_CTRL_RES_LO])
         `SARC_RES_10: nbits = `SARC_BITS_10;
         `SARC_RES_12: nbits = `SARC_BITS_12;
         `SARC_RES_8:  nbits = `SARC_BITS_8;
         default:      nbits = `SARC_BITS_12;
      endcase
   end

   assign sample_len = {1'b0, stc_r} + `SARC_SAMPLE_EXTRA;

   // Conversion ends after distribution, or after calibration when enabled
   assign conv_done = tick && (
      (phase_r == SARC_DISTRIB && cnt_r == {5'h00, nbits} - 9'h001
       && mode_r[`SARC_CTRL_NOCAL_BIT]) ||
      (phase_r == SARC_CAL && cnt_r == {5'h00, `SARC_CAL_TICKS} - 9'h001));

   // ----------------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------------
   // A start during a conversion drops it and begins afresh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= SARC_IDLE;
         cnt_r   <= '0;
      end else if (start) begin
         phase_r <= SARC_SAMPLE;
         cnt_r   <= '0;
      end else if (tick) begin
         cnt_r <= cnt_r + 9'h001;
         case (phase_r)
            SARC_SAMPLE: begin
               if (cnt_r == sample_len - 9'h001) begin
                  phase_r <= SARC_DISTRIB;
                  cnt_r   <= '0;
               end
            end
            SARC_DISTRIB: begin
               if (cnt_r == {5'h00, nbits} - 9'h001) begin
                  phase_r <= mode_r[`SARC_CTRL_NOCAL_BIT]
                             ? SARC_IDLE : SARC_CAL;
                  cnt_r   <= '0;
               end
            end
            SARC_CAL: begin
               if (conv_done) begin
                  phase_r <= SARC_IDLE;
                  cnt_r   <= '0;
               end
            end
            default: begin
               cnt_r <= '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy        <= 1'b0;
         sampling    <= 1'b0;
         calibrating <= 1'b0;
      end else begin
         busy     <= start
                     || (phase_r != SARC_IDLE && !conv_done);
         sampling <= start || (phase_r == SARC_SAMPLE && !(tick
                     && cnt_r == sample_len - 9'h001));
         calibrating <= !start && ((phase_r == SARC_CAL && !conv_done) ||
                        (phase_r == SARC_DISTRIB && tick
                         && !mode_r[`SARC_CTRL_NOCAL_BIT]
                         && cnt_r == {5'h00, nbits} - 9'h001));
      end
   end

   // Valid rises as busy falls and holds until the next start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_valid <= 1'b0;
      end else if (start) begin
         result_valid <= 1'b0;
      end else if (conv_done) begin
         result_valid <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Result latch with justification
   // ----------------------------------------------------------------------
   // Result holds through the next conversion until it too completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= '0;
      end else if (conv_done && !start) begin
         case (mode_r[`SARC_CTRL_RES_HI:`SARC_CTRL_RES_LO])
            `SARC_RES_8:  result <= {sar_raw[RES_W-1:4], 4'h0};
            `SARC_RES_10: result <= {sar_raw[RES_W-1:2], 2'h0};
            default:      result <= sar_raw;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Power control
   // ----------------------------------------------------------------------
   // Comparators stay up between conversions only when bit 2 is set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_powered <= 1'b0;
      end else if (start) begin
         converter_powered <= 1'b1;
      end else if (phase_r == SARC_IDLE || conv_done) begin
         converter_powered <= mode_r[`SARC_CTRL_NOPD_BIT];
      end
   end

endmodule
`default_nettype wire

// >>> design/sarc_regs.svh
/*
 * Register map, field positions, reset values and timing constants for the
 * converter control block.
 * Assumes inclusion by bare name from design files of this block and from the bench.
 */
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SARC_CTRL_OFS      12'h000
`define SARC_TIMING_OFS    12'h004
`define SARC_STATUS_OFS    12'h008
`define SARC_RESULT_OFS    12'h00C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SARC_CTRL_START_BIT   8
`define SARC_CTRL_REF_BIT     4
`define SARC_CTRL_NOCAL_BIT   3
`define SARC_CTRL_NOPD_BIT    2
`define SARC_CTRL_RES_HI      1
`define SARC_CTRL_RES_LO      0

// ----------------------------------------------------------------------
// Timing register fields
// ----------------------------------------------------------------------
`define SARC_TIM_DIV_HI    7
`define SARC_TIM_DIV_LO    0
`define SARC_TIM_STC_HI    15
`define SARC_TIM_STC_LO    8

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SARC_ST_BUSY_BIT    0
`define SARC_ST_SAMPLE_BIT  1
`define SARC_ST_VALID_BIT   2
`define SARC_ST_PWR_BIT     3

// ----------------------------------------------------------------------
// Resolution codes and phase lengths
// ----------------------------------------------------------------------
`define SARC_RES_10         2'h0
`define SARC_RES_12         2'h1
`define SARC_RES_8          2'h2
`define SARC_BITS_8         4'h8
`define SARC_BITS_10        4'hA
`define SARC_BITS_12        4'hC
`define SARC_SAMPLE_EXTRA   9'h002
`define SARC_CAL_TICKS      4'h2
`define SARC_TICK_QUARTERS  2'h3

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define SARC_CTRL_RST       4'h0
`define SARC_DIV_RST        8'h00
`define SARC_STC_RST        8'h00
`define SARC_RESP_OKAY      2'h0
`define SARC_RESP_SLVERR    2'h2

`endif

// >>> design/sarc_pkg.sv
/*
 * Types shared by the converter control block.
 * Assumes the register header is included alongside where needed.
 */
package sarc_pkg;

   // Conversion sequencer phases
   typedef enum logic [1:0] {
      SARC_IDLE,
      SARC_SAMPLE,
      SARC_DISTRIB,
      SARC_CAL
   } sarc_phase_e;

endpackage

// >>> design/sarc_clkdiv.sv
/*
 * Converter clock tick generator: one tick every 4*(1+div) system clocks.
 * Assumes a single clock; restart realigns the tick to a new conversion.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sarc_regs.svh"

module sarc_clkdiv #(
   parameter int DIV_W = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             restart,
   input  wire logic [DIV_W-1:0] div,
   output logic                  tick
);

   logic [DIV_W-1:0] pre_r;
   logic [1:0]       quarter_r;

   // ----------------------------------------------------------------------
   // Divider chain
   // ----------------------------------------------------------------------
   // Kept internal: the converter clock never reaches a pin, only this tick
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         pre_r     <= '0;
         quarter_r <= '0;
      end else if (pre_r == div) begin
         pre_r     <= '0;
         quarter_r <= quarter_r + 2'h1;
      end else begin
         pre_r <= pre_r + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // Tick on the last system clock of each 4*(1+div) period
   assign tick = aresetn && !restart && (pre_r == div)
                 && (quarter_r == `SARC_TICK_QUARTERS);

endmodule
`default_nettype wire

// >>> design/sarc_axil.sv
/*
 * AXI4-Lite slave front end: accepts one write and one read at a time.
 * Assumes the core decodes addresses and returns read data combinationally.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sarc_regs.svh"

module sarc_axil #(
   parameter int AW = 12
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic               wr_en,
   output logic [AW-1:0]      wr_addr,
   output logic [31:0]        wr_data,
   output logic [3:0]         wr_strb,
   input  wire logic          wr_err,
   output logic [AW-1:0]      rd_addr,
   input  wire logic [31:0]   rd_data,
   input  wire logic          rd_err
);

   logic          aw_have_r;
   logic          w_have_r;
   logic [AW-1:0] awaddr_r;
   logic [31:0]   wdata_r;
   logic [3:0]    wstrb_r;

   // ----------------------------------------------------------------------
   // Write path: capture address and data in either order
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_en) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? `SARC_RESP_SLVERR : `SARC_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Commit once both halves are held and no response is pending
   assign wr_en   = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_addr = awaddr_r;
   assign wr_data = wdata_r;
   assign wr_strb = wstrb_r;

   // ----------------------------------------------------------------------
   // Read path: data registered on acceptance
   // ----------------------------------------------------------------------
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= 2'h0;
      end else begin
         // Ready stays up while idle, so a waiting address is always taken
         s_axi_arready <= !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? `SARC_RESP_SLVERR : `SARC_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb/sarc_user_model.sv
/* User fabric logic model: start strobe and raw bits.
   Assumes the bench asks for starts through go. */
`timescale 1ns/1ns
`default_nettype none
module sarc_user_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        go,
   input  wire logic        busy,
   input  wire logic [11:0] raw,
   output logic             conversion_start,
   output logic [11:0]      sar_raw
);
   // One-cycle strobe launched just after an edge
   always_ff @(posedge aclk) conversion_start <= go && aresetn;
   // Raw bits hold only while converting, else inverted to expose slips
   assign sar_raw = busy ? raw : ~raw;
endmodule
`default_nettype wire

// >>> tb/sarc_ctrl_checker.sv
/* Checker of the status flag sequence of sarc_ctrl.
   Assumes it is bound to sarc_ctrl and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module sarc_ctrl_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        conversion_start,
   input wire logic [11:0] result,
   input wire logic        busy,
   input wire logic        sampling,
   input wire logic        result_valid,
   input wire logic        calibrating
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // State on the edge after a pin start; a register start is not seen here
   sequence s_conv_begin;
      busy && sampling && !result_valid;
   endsequence
   a_start_flags: assert property (
      conversion_start |=> s_conv_begin)
      else $error("start not followed by busy and sampling");
   a_samp_busy: assert property (sampling |-> busy)
      else $error("sampling without busy");
   a_rise_both: assert property ($rose(busy) |-> $rose(sampling))
      else $error("busy rose without sampling");
   a_fell_valid: assert property ($fell(busy) |-> result_valid)
      else $error("no valid at end of conversion");
   // A register start has no pin here: valid may only give way to a new run
   a_valid_hold: assert property (
      result_valid && !conversion_start
      |=> $stable(result) && (result_valid || (busy && sampling)))
      else $error("result dropped before next start");
   a_valid_idle: assert property (result_valid |-> !busy)
      else $error("valid while busy");
   a_cal_phase: assert property (
      calibrating |-> busy && !sampling)
      else $error("calibration outside conversion");
   a_distrib_busy: assert property ($fell(sampling) |-> busy)
      else $error("busy low after sampling");
endmodule
bind sarc_ctrl sarc_ctrl_checker i_sarc_ctrl_checker (.aclk(aclk),
   .aresetn(aresetn), .conversion_start(conversion_start), .result(result),
   .busy(busy), .sampling(sampling), .result_valid(result_valid),
   .calibrating(calibrating));
`default_nettype wire

// >>> tb/tb.sv
/* Bench: register setup over AXI4-Lite, conversions and result checks.
   Assumes design, checker and user model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "sarc_regs.svh"
module tb;
   logic        aclk = 0, aresetn = 0, go = 0, rv_d = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, raw = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_bready = 1, s_axi_rready = 1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, busy, sampling, result_valid, calibrating;
   logic        converter_powered, reference_select, conversion_start;
   logic [1:0]  s_axi_bresp, s_axi_rresp, res;
   logic [11:0] sar_raw, result, exp_q[$];
   logic [3:0]  md;
   logic [7:0]  dv, st;
   int          mismatches = 0, num_checks = 0, seed = 85, nb, ns, nc, tk;
   sarc_ctrl i_sarc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conversion_start,
      .sar_raw, .result, .busy, .sampling, .result_valid, .calibrating,
      .converter_powered, .reference_select);
   sarc_user_model i_sarc_user_model (.aclk, .aresetn, .go, .busy, .raw,
      .conversion_start, .sar_raw);
   initial forever #10 aclk = ~aclk;
   // Generous bound: each conversion is a few hundred cycles at most
   initial begin
      #400000;
      mismatches++;
      finish_test;
   end
   task automatic finish_test;
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while ((s_axi_awvalid && !s_axi_awready) ||
                 (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      check(s_axi_bresp, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] r,
                     input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      check(s_axi_rresp, r);
      check(s_axi_rdata, e);
   endtask
   // Result watcher: one note taken per rising valid
   always @(posedge aclk) begin
      if (result_valid && !rv_d && exp_q.size() > 0) begin
         check(result, exp_q.pop_front());
      end
      rv_d <= result_valid;
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      check(result_valid, 0);
      rd(12'h010, `SARC_RESP_SLVERR, 32'h0000_0000);
      wr(`SARC_STATUS_OFS, 32'h0000_0001, `SARC_RESP_SLVERR);
      for (int i = 0; i < 9; i++) begin
         res = i % 3;
         md = {$random(seed)} % 4 * 4 + res;
         dv = 1 + {$random(seed)} % 2;
         st = 3 + {$random(seed)} % 2;
         raw <= $random(seed);
         wr(`SARC_CTRL_OFS, {27'h0, i[0], md}, `SARC_RESP_OKAY);
         wr(`SARC_TIMING_OFS, {16'h0, st, dv}, `SARC_RESP_OKAY);
         rd(`SARC_TIMING_OFS, `SARC_RESP_OKAY, {16'h0, st, dv});
         check(reference_select, i[0]);
         exp_q.push_back(raw & (res == 2 ? 12'hFF0 : res == 0 ? 12'hFFC
                                : 12'hFFF));
         nb = 0;
         ns = 0;
         nc = 0;
         // Last pass starts through the control register, not the pin
         if (i == 8) begin
            wr(`SARC_CTRL_OFS, {27'h0, i[0], md} | 32'h0000_0100,
               `SARC_RESP_OKAY);
         end else begin
            go <= 1;
            @(posedge aclk);
            go <= 0;
            repeat (2) @(posedge aclk);
         end
         for (int t = 0; t < 3000 && !result_valid; t++) begin
            nb += busy;
            ns += sampling;
            nc += calibrating;
            @(posedge aclk);
         end
         tk = 4 * (1 + dv);
         check(ns, tk * (2 + st));
         check(nb, tk * (2 + st + (res == 2 ? 8 : res == 0 ? 10 : 12)
                   + (md[3] ? 0 : 2)));
         check(nc, md[3] ? 0 : 2 * tk);
         check(converter_powered, md[2]);
         rd(`SARC_STATUS_OFS, `SARC_RESP_OKAY,
            {28'h0, md[2], 3'h4});
      end
      repeat (2) @(posedge aclk);
      check(exp_q.size(), 0);
      finish_test;
   end
endmodule
`default_nettype wire
